// [common/bieacc_pkg.sv]
package bieacc_pkg;
  // Register addresses
  localparam logic [8:0] ADDR_CONTROL = 9'h181;
  localparam logic [8:0] ADDR_ENABLE = 9'h182;
  localparam logic [8:0] ADDR_POINTER = 9'h183;
  localparam logic [8:0] ADDR_DATA_HIGH = 9'h184;
  localparam logic [8:0] ADDR_DATA_LOW = 9'h185;
  // Field positions
  localparam int CTL_READ_BIT = 0;
  localparam int CTL_WRITE_BIT = 1;
  localparam int CTL_HV_BIT = 3;
  localparam int ENA_BIT = 7;
  // Array geometry
  localparam int WORD_BITS = 16;
  localparam int PTR_BITS = 6;
  localparam int WORDS = 64;
  localparam logic [5:0] PTR_LAST = 6'h3f;
  // Reset values
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [WORD_BITS-1:0] CELL_BLANK = 16'hffff;
  // Access timing
  localparam int READ_TIME_NS = 100;
  localparam int WRITE_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int READ_CYCLES = (READ_TIME_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int CNT_BITS = 8;
endpackage

// [logic/bieacc_array.sv]
`timescale 1ns/1ps
// One-time-programmable word array: programming can only clear bits
module bieacc_array
(
  input wire logic mclk, // Clock
  input wire logic [5:0] addr, // Word address
  input wire logic rd_en, // Read strobe
  input wire logic wr_en, // Program strobe
  input wire logic [15:0] wdata, // Word to program
  output logic [15:0] rdata // Word read, registered
);
  logic [15:0] cells [0:63];

  // Blank cells start erased
  initial
  begin
    for (int i = 0; i < 64; i++)
      cells[i] = bieacc_pkg::CELL_BLANK;
  end

  // Read and program port
  always_ff @(posedge mclk)
  begin
    if (wr_en)
      cells[addr] <= cells[addr] & wdata;
    if (rd_en)
      rdata <= cells[addr];
  end
endmodule

// [logic/bieacc_top.sv]
`timescale 1ns/1ps
// How it works
// (R1) No array access unless enable bit set; enable is checked only when an access starts, not during it
// (R2) Software keeps enable register other bits zero
// (R3) Pointer keeps all eight bits; reads return six low bits, 00h to 3Fh
// (R4) Read request loads word into data bytes
// (R5) Hardware clears read request when done
// (R6) Pointer increments after access, stops 3Fh
// (R7) Voltage status bit follows supply pin directly
// (R8) Write request programs data bytes at pointer
// (R9) Software loads data bytes before write
// (R10) Hardware clears write request when done
// (R11) Pointer beyond 3Fh moves no data
// (R12) Software never sets both requests together
// (R13) Software disables converter around accesses
// (R14) Software polls read request before using data
// (R15) Software checks supply status before writing
// (R16) Write without supply: array untouched, request cleared
// (R17) Request stays set; data updates at end
module bieacc_top
(
  input wire logic mclk, // Clock, 200 MHz
  input wire logic rst, // Async reset, active high
  input wire logic [8:0] reg_addr, // Register address
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [7:0] reg_wdata, // Register write data
  output logic [7:0] reg_rdata, // Register read data
  input wire logic programming_supply_input // High when 6 V supply present
);
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } bieacc_state_t;

  typedef struct packed
  {
    bieacc_state_t state;
    logic read_request;
    logic write_request;
    logic eprom_access_enable;
    logic [7:0] word_pointer;
    logic [7:0] data_high;
    logic [7:0] data_low;
    logic [7:0] count;
    logic [7:0] rdata;
  } bieacc_regs_t;

  bieacc_regs_t s_reg;
  bieacc_regs_t s_next;
  logic [15:0] arr_rdata;
  logic arr_rd;
  logic arr_wr;
  logic high_voltage_flag;
  logic ptr_ok;

  // Decode one register address
  function automatic logic hit(input logic [8:0] a, input logic [8:0] r);
    hit = (a == r);
  endfunction

  // Supply status tracks the pin with no delay
  assign high_voltage_flag = programming_supply_input; // R7
  // Only pointers inside the array may move data
  assign ptr_ok = (s_reg.word_pointer[7:6] == 2'b00); // R3 R11

  // Next-state logic: bus writes, access sequencing
  always_comb
  begin
    s_next = s_reg;
    arr_rd = 1'b0;
    arr_wr = 1'b0;
    if (reg_wr)
    begin
      if (hit(reg_addr, bieacc_pkg::ADDR_ENABLE))
        s_next.eprom_access_enable = reg_wdata[bieacc_pkg::ENA_BIT];
      if (hit(reg_addr, bieacc_pkg::ADDR_POINTER) &&
          s_reg.state == ST_IDLE)
        s_next.word_pointer = reg_wdata;
      if (hit(reg_addr, bieacc_pkg::ADDR_DATA_HIGH) &&
          s_reg.state == ST_IDLE)
        s_next.data_high = reg_wdata;
      if (hit(reg_addr, bieacc_pkg::ADDR_DATA_LOW) &&
          s_reg.state == ST_IDLE)
        s_next.data_low = reg_wdata;
      if (hit(reg_addr, bieacc_pkg::ADDR_CONTROL) &&
          s_reg.state == ST_IDLE)
      begin
        s_next.read_request = reg_wdata[bieacc_pkg::CTL_READ_BIT];
        s_next.write_request = reg_wdata[bieacc_pkg::CTL_WRITE_BIT];
      end
    end
    case (s_reg.state)
      ST_IDLE:
      begin
        s_next.count = '0;
        if (s_reg.read_request && s_reg.write_request)
        begin
          // Both set is undefined; drop both without an access
          s_next.read_request = 1'b0; // R12
          s_next.write_request = 1'b0;
        end
        else if (s_reg.read_request || s_reg.write_request)
        begin
          if (!s_reg.eprom_access_enable)
          begin
            // Requests wait until access is enabled
            s_next.read_request = s_reg.read_request; // R1
          end
          else if (s_reg.read_request)
            s_next.state = ST_READ; // R4
          else
            s_next.state = ST_WRITE; // R8
        end
      end
      ST_READ:
      begin
        s_next.count = s_reg.count + 8'h01;
        if (s_reg.count ==
            8'(bieacc_pkg::READ_CYCLES - 2))
          arr_rd = ptr_ok; // R11
        if (s_reg.count ==
            8'(bieacc_pkg::READ_CYCLES - 1))
        begin
          if (ptr_ok)
          begin
            s_next.data_high = arr_rdata[15:8]; // R4 R17
            s_next.data_low = arr_rdata[7:0];
            if (s_reg.word_pointer[5:0] != bieacc_pkg::PTR_LAST)
              s_next.word_pointer = s_reg.word_pointer + 8'h01; // R6
          end
          s_next.read_request = 1'b0; // R5 R17
          s_next.state = ST_IDLE;
        end
      end
      ST_WRITE:
      begin
        s_next.count = s_reg.count + 8'h01;
        if (s_reg.count ==
            8'(bieacc_pkg::WRITE_CYCLES - 1))
        begin
          // Program only with supply present and pointer valid
          arr_wr = ptr_ok && high_voltage_flag; // R8 R11 R16
          if (ptr_ok && high_voltage_flag &&
              s_reg.word_pointer[5:0] != bieacc_pkg::PTR_LAST)
            s_next.word_pointer = s_reg.word_pointer + 8'h01; // R6
          s_next.write_request = 1'b0; // R10 R16 R17
          s_next.state = ST_IDLE;
        end
      end
      default:
      begin
        s_next.state = ST_IDLE;
        s_next.read_request = 1'b0;
        s_next.write_request = 1'b0;
      end
    endcase
    // Read data mux, registered
    if (reg_rd)
    begin
      if (hit(reg_addr, bieacc_pkg::ADDR_CONTROL))
        s_next.rdata = {4'h0, high_voltage_flag, 1'b0,
          s_reg.write_request, s_reg.read_request}; // R7
      else if (hit(reg_addr, bieacc_pkg::ADDR_ENABLE))
        s_next.rdata = {s_reg.eprom_access_enable, 7'h00};
      else if (hit(reg_addr, bieacc_pkg::ADDR_POINTER))
        s_next.rdata = {2'b00, s_reg.word_pointer[5:0]}; // R3
      else if (hit(reg_addr, bieacc_pkg::ADDR_DATA_HIGH))
        s_next.rdata = s_reg.data_high;
      else if (hit(reg_addr, bieacc_pkg::ADDR_DATA_LOW))
        s_next.rdata = s_reg.data_low;
      else
        s_next.rdata = 8'h00;
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_reg.state <= ST_IDLE;
      s_reg.read_request <= 1'b0;
      s_reg.write_request <= 1'b0;
      s_reg.eprom_access_enable <= 1'b0;
      s_reg.word_pointer <= bieacc_pkg::PTR_RESET;
      s_reg.data_high <= bieacc_pkg::DATA_RESET;
      s_reg.data_low <= bieacc_pkg::DATA_RESET;
      s_reg.count <= 8'h00;
      s_reg.rdata <= 8'h00;
    end
    else
      s_reg <= s_next;
  end

  assign reg_rdata = s_reg.rdata;

  // Word array
  bieacc_array u_array
  (
    .mclk(mclk),
    .addr(s_reg.word_pointer[5:0]),
    .rd_en(arr_rd),
    .wr_en(arr_wr),
    .wdata({s_reg.data_high, s_reg.data_low}),
    .rdata(arr_rdata)
  );
endmodule

// [testbench/bieacc_supply.sv]
`timescale 1ns/1ps
// ----------------------------------
// External programming supply source
// ----------------------------------
module bieacc_supply
#(
  parameter int RAMP = 6 // Cycles to settle
)
(
  input wire logic mclk, // Clock
  input wire logic on, // Supply switched on
  output logic supply // Pin level, high when present
);
  int cnt = 0;
  // Counts up the ramp, restarts once removed
  always @(posedge mclk)
  begin
    cnt <= on ? (cnt < RAMP ? cnt + 1 : cnt) : 0;
  end
  // Present only after the ramp, gone at once
  assign supply = on && cnt == RAMP;
endmodule

// [testbench/bieacc_props.sv]
`timescale 1ns/1ps
// ----------------------------------
// Port checks of the access unit
// ----------------------------------
module bieacc_props
(
  input wire logic mclk, // Clock
  input wire logic rst, // Reset
  input wire logic [8:0] reg_addr, // Address
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic programming_supply_input // Supply pin
);
  // Decoded accesses
  wire rc = reg_rd && reg_addr == bieacc_pkg::ADDR_CONTROL;
  wire rp = reg_rd && reg_addr == bieacc_pkg::ADDR_POINTER;
  wire re = reg_rd && reg_addr == bieacc_pkg::ADDR_ENABLE;
  wire rh = reg_rd && reg_addr == bieacc_pkg::ADDR_DATA_HIGH;
  wire wh = reg_wr && reg_addr == bieacc_pkg::ADDR_DATA_HIGH;
  wire wc = reg_wr && reg_addr == bieacc_pkg::ADDR_CONTROL;
  wire ru = reg_rd && reg_addr > bieacc_pkg::ADDR_DATA_LOW;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  supply_flag_a: assert property (
    rc |=> reg_rdata[3] == $past(programming_supply_input))
    else $error("supply flag wrong");
  ptr_width_a: assert property (
    rp |=> reg_rdata[7:6] == 2'h0) else $error("pointer too wide");
  enable_only_a: assert property (
    re |=> reg_rdata[6:0] == 7'h00) else $error("enable bits");
  rdata_hold_a: assert property (
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  data_keep_a: assert property (
    wh ##2 rh |=> reg_rdata == $past(reg_wdata, 3))
    else $error("high byte lost");
  req_stand_a: assert property (
    wc && reg_wdata == 8'h01 ##2 rc |=> reg_rdata[0])
    else $error("request dropped");
  rst_clear_a: assert property (
    $fell(rst) |-> reg_rdata == 8'h00) else $error("reset data");
  unmapped_a: assert property (
    ru |=> reg_rdata == 8'h00) else $error("unmapped data");
endmodule
bind bieacc_top bieacc_props i_props (.mclk(mclk), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .programming_supply_input(programming_supply_input));

// [testbench/test_builtin_eprom_access.sv]
`timescale 1ns/1ps
module test_builtin_eprom_access;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sup_on = 1'b0;
  logic [8:0] reg_addr = 9'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] v;
  logic programming_supply_input;
  int num_errors = 0;
  int total_checks = 0;
  localparam logic [8:0] CT = bieacc_pkg::ADDR_CONTROL;
  localparam logic [8:0] PT = bieacc_pkg::ADDR_POINTER;
  localparam logic [8:0] DH = bieacc_pkg::ADDR_DATA_HIGH;
  // ----------------------------------
  // Design, supply and register tasks
  // ----------------------------------
  bieacc_top i_bieacc_top (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .programming_supply_input(programming_supply_input));
  bieacc_supply i_bieacc_supply (.mclk(mclk), .on(sup_on),
    .supply(programming_supply_input));
  always #2.5 mclk = ~mclk;
  task wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [8:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task rck(input logic [8:0] a, input logic [7:0] e);
    rd(a);
    chk(v, e);
  endtask
  task give_verdict();
    if (num_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Polls control until the masked bits match, bounded
  task poll(input logic [7:0] m, input logic [7:0] w);
    for (int n = 0; n < 300; n++)
    begin
      rd(CT);
      if ((v & m) === w)
        return;
    end
    num_errors++;
    give_verdict();
  endtask
  // Main sequence
  initial
  begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rck(PT, 8'h00);
    rck(9'h186, 8'h00);
    rck(CT, 8'h00);
    wr(CT, 8'h01);
    rck(CT, 8'h01);
    repeat (30) @(posedge mclk);
    rck(CT, 8'h01);
    // Converter sits outside this block; nothing to switch off
    wr(9'h182, 8'h80);
    rck(9'h182, 8'h80);
    rck(DH, 8'h00);
    poll(8'h01, 8'h00);
    rck(DH, 8'hff);
    rck(PT, 8'h01);
    sup_on <= 1'b1;
    poll(8'h08, 8'h08);
    wr(PT, 8'h02);
    wr(DH, 8'h12);
    rck(DH, 8'h12);
    wr(9'h185, 8'h34);
    wr(CT, 8'h02);
    poll(8'h02, 8'h00);
    rck(PT, 8'h03);
    // Clear the data bytes so the read must refill them
    wr(DH, 8'h00);
    wr(9'h185, 8'h00);
    wr(PT, 8'h02);
    wr(CT, 8'h01);
    poll(8'h01, 8'h00);
    rck(DH, 8'h12);
    rck(9'h185, 8'h34);
    sup_on <= 1'b0;
    wr(PT, 8'h04);
    wr(DH, 8'h00);
    wr(CT, 8'h02);
    poll(8'h02, 8'h00);
    rck(PT, 8'h04);
    wr(CT, 8'h01);
    poll(8'h01, 8'h00);
    rck(DH, 8'hff);
    wr(PT, 8'h3f);
    wr(CT, 8'h01);
    poll(8'h01, 8'h00);
    rck(PT, 8'h3f);
    // Both requests at once are dropped with no access
    wr(CT, 8'h03);
    rck(CT, 8'h00);
    wr(PT, 8'h40);
    wr(DH, 8'h5a);
    wr(CT, 8'h01);
    poll(8'h01, 8'h00);
    rck(DH, 8'h5a);
    rck(PT, 8'h00);
    give_verdict();
  end
endmodule
